// File: rtl/srm_sync_ref_mode.sv
`timescale 1ns/10ps
`default_nettype none
module srm_sync_ref_mode #(
    parameter int unsigned FRAME_CYC = srm_pkg::FRAME_CYC,
    parameter int unsigned PULSE_CYC = srm_pkg::PULSE_CYC
) (
    input  wire logic       i_mclk,
    input  wire logic       i_rstn,
    input  wire logic       i_primary_ref_lost,
    input  wire logic       i_secondary_ref_lost,
    input  wire logic       i_guard_time_in,
    input  wire logic       i_ctrl_select_low,
    input  wire logic       i_ctrl_select_high,
    input  wire logic       i_ref_source_pick,
    input  wire logic       i_freq_pick_low,
    input  wire logic       i_freq_pick_high,
    input  wire logic       i_test_enable,
    input  wire logic       i_ref_align,
    input  wire logic       i_tck,
    input  wire logic       i_tms,
    input  wire logic       i_tdi,
    input  wire logic       i_scan_tdo,
    input  wire logic       i_pll_holdover,
    output logic            o_frame_pulse_8k,
    output logic            o_clocks_high,
    output logic            o_phase_align,
    output logic            o_manual,
    output logic [1:0]      o_state,
    output logic            o_use_secondary,
    output logic            o_primary_lost,
    output logic            o_secondary_lost,
    output logic            o_guard_time,
    output logic [1:0]      o_freq_sel,
    output logic            o_freq_reserved,
    output logic            o_test_mode,
    output logic            o_holdover,
    output logic            o_tdo,
    output logic            o_tdo_oe_n,
    output logic            o_scan_enable,
    output logic [3:0]      o_tap_state
);
    if (FRAME_CYC < 4 || PULSE_CYC < 1 || PULSE_CYC >= FRAME_CYC) begin : g_bad_timing
        $error("srm: bad frame timing parameters");
    end

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    localparam int NSYNC = 13;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    wire  [NSYNC-1:0] raw = {i_ref_align, i_tdi, i_tms, i_tck, i_test_enable,
                             i_freq_pick_high, i_freq_pick_low, i_ref_source_pick,
                             i_ctrl_select_high, i_ctrl_select_low, i_guard_time_in,
                             i_secondary_ref_lost, i_primary_ref_lost};
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= raw;
            sync_b <= sync_a;
        end
    end
    wire s_prim_lost   = sync_b[0];
    wire s_second_lost = sync_b[1];
    wire s_guard       = sync_b[2];
    wire s_sel_low     = sync_b[3];
    wire s_sel_high    = sync_b[4];
    wire s_src_pick    = sync_b[5];
    wire s_fpick_low   = sync_b[6];
    wire s_fpick_high  = sync_b[7];
    wire s_test = sync_b[8];
    wire s_tck  = sync_b[9];
    wire s_tms  = sync_b[10];
    wire s_tdi  = sync_b[11];
    wire s_algn = sync_b[12];

    ////////////////////////////////////////////////////////////////////////////
    // frame pulse generator, realigned to the reference after reset
    logic [$clog2(FRAME_CYC)-1:0] fcnt;
    logic                         aligned;
    logic                         algn_d;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            fcnt    <= '0;
            aligned <= 1'b0;
            algn_d  <= 1'b0;
        end else begin
            algn_d <= s_algn;
            if (!aligned && s_algn && !algn_d) begin
                fcnt    <= '0;
                aligned <= 1'b1;
            end else if (fcnt == ($clog2(FRAME_CYC))'(FRAME_CYC - 1)) begin
                fcnt <= '0;
            end else begin
                fcnt <= fcnt + 1'b1;
            end
        end
    end
    logic next_fp;
    always_comb begin
        next_fp = aligned && (fcnt < ($clog2(FRAME_CYC))'(PULSE_CYC));
    end
    logic fp;
    logic fp_d;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            fp   <= 1'b0;
            fp_d <= 1'b0;
        end else begin
            fp   <= next_fp;
            fp_d <= fp;
        end
    end
    wire fp_rise = fp && !fp_d;
    assign o_frame_pulse_8k = !aligned ? 1'b1 : fp;
    assign o_clocks_high    = !i_rstn || !aligned;
    assign o_phase_align    = aligned;

    ////////////////////////////////////////////////////////////////////////////
    // frame-edge sampling of control levels
    logic samp_prim_lost;
    logic samp_second_lost;
    logic samp_guard;
    logic samp_sel_low;
    logic samp_sel_high;
    logic samp_src_pick;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            samp_prim_lost   <= 1'b0;
            samp_second_lost <= 1'b0;
            samp_guard       <= 1'b0;
            samp_sel_low     <= 1'b0;
            samp_sel_high    <= 1'b0;
            samp_src_pick    <= 1'b0;
        end else if (fp_rise) begin
            samp_prim_lost   <= s_prim_lost;
            samp_second_lost <= s_second_lost;
            samp_guard       <= s_guard;
            samp_sel_low     <= s_sel_low;
            samp_sel_high    <= s_sel_high;
            samp_src_pick    <= s_src_pick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode decode, select high then low: 00 normal, 01 holdover, 10 freerun, 11 manual control
    localparam logic [1:0] SRM_NORMAL_C   = 2'(srm_pkg::SRM_NORMAL);
    localparam logic [1:0] SRM_HOLDOVER_C = 2'(srm_pkg::SRM_HOLDOVER);
    localparam logic [1:0] SRM_FREERUN_C  = 2'(srm_pkg::SRM_FREERUN);
    always_comb begin
        o_manual = samp_sel_high & samp_sel_low;
        unique case ({samp_sel_high, samp_sel_low})
            2'h1:    o_state = SRM_HOLDOVER_C;
            2'h2:    o_state = SRM_FREERUN_C;
            default: o_state = SRM_NORMAL_C;
        endcase
    end

    // manual uses the select pin; automatic relies on the two loss levels
    assign o_use_secondary  = o_manual ? samp_src_pick : (samp_prim_lost & !samp_second_lost);
    assign o_primary_lost   = samp_prim_lost;
    assign o_secondary_lost = samp_second_lost;
    assign o_guard_time     = samp_guard;

    ////////////////////////////////////////////////////////////////////////////
    // frequency select, test mode, holdover
    logic [1:0] freq;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            freq <= srm_pkg::FREQ_RSVD;
        end else begin
            freq <= {s_fpick_high, s_fpick_low};
        end
    end
    assign o_freq_sel      = freq;
    assign o_freq_reserved = (freq == srm_pkg::FREQ_RSVD);
    assign o_test_mode     = s_test;
    assign o_holdover      = i_pll_holdover || (o_state == SRM_HOLDOVER_C);

    ////////////////////////////////////////////////////////////////////////////
    // tap controller on sampled test clock
    typedef enum logic [3:0] {
        TLR, RTI, SDS, CDR, SHD, E1D, PSD, E2D, UDR,
        SIS, CIR, SHI, E1I, PSI, E2I, UIR
    } srm_tap_t;
    srm_tap_t tap;
    srm_tap_t next_tap;
    logic     tck_d;
    wire tck_rise = s_tck && !tck_d;
    wire tck_fall = !s_tck && tck_d;
    always_comb begin
        unique case (tap)
            TLR: next_tap = s_tms ? TLR : RTI;
            RTI: next_tap = s_tms ? SDS : RTI;
            SDS: next_tap = s_tms ? SIS : CDR;
            CDR: next_tap = s_tms ? E1D : SHD;
            SHD: next_tap = s_tms ? E1D : SHD;
            E1D: next_tap = s_tms ? UDR : PSD;
            PSD: next_tap = s_tms ? E2D : PSD;
            E2D: next_tap = s_tms ? UDR : SHD;
            UDR: next_tap = s_tms ? SDS : RTI;
            SIS: next_tap = s_tms ? TLR : CIR;
            CIR: next_tap = s_tms ? E1I : SHI;
            SHI: next_tap = s_tms ? E1I : SHI;
            E1I: next_tap = s_tms ? UIR : PSI;
            PSI: next_tap = s_tms ? E2I : PSI;
            E2I: next_tap = s_tms ? UIR : SHI;
            UIR: next_tap = s_tms ? SDS : RTI;
        endcase
    end
    logic shift_bit;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            tap       <= TLR;
            tck_d     <= 1'b0;
            shift_bit <= 1'b0;
        end else begin
            tck_d <= s_tck;
            if (tck_rise) begin
                tap <= next_tap;
                if (tap == SHD || tap == SHI) begin
                    shift_bit <= s_tdi;
                end
            end
        end
    end
    wire shifting = (tap == SHD) || (tap == SHI);
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_tdo      <= 1'b0;
            o_tdo_oe_n <= 1'b1;
        end else if (tck_fall) begin
            // data shift path is a one-bit bypass stage fed from tdi
            o_tdo      <= (tap == SHD) ? shift_bit : i_scan_tdo;
            o_tdo_oe_n <= !shifting;
        end
    end
    assign o_scan_enable = shifting;
    assign o_tap_state   = tap;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    // length of the running frame pulse, so the width check needs no long repetition
    logic [$clog2(FRAME_CYC)-1:0] fp_len;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            fp_len <= '0;
        end else if (fp) begin
            fp_len <= fp_len + 1'b1;
        end else begin
            fp_len <= '0;
        end
    end
    a_frame_sample_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        !fp_rise |=> $stable(samp_sel_low) && $stable(samp_sel_high) && $stable(samp_src_pick))
        else $error("mode sample changed between frame edges");
    a_sample_capture: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        fp_rise |=> samp_prim_lost == $past(s_prim_lost))
        else $error("loss level not captured at frame edge");
    a_outputs_high_unaligned: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        !aligned |-> o_frame_pulse_8k && o_clocks_high)
        else $error("outputs not high before alignment");
    a_pulse_width: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        $fell(fp) |-> fp_len == ($clog2(FRAME_CYC))'(PULSE_CYC))
        else $error("frame pulse width wrong");
    a_manual_select: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        o_manual |-> o_use_secondary == samp_src_pick)
        else $error("manual reference select wrong");
    a_holdover_out: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        i_pll_holdover |-> o_holdover)
        else $error("holdover indicator low");
    a_tdo_idle_hiz: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (tap == TLR) && $past(tap == TLR) && $past(tap == TLR, 2) |-> o_tdo_oe_n)
        else $error("tdo driven while scan idle");
    a_tap_reset_tms: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        tck_rise && s_tms && tap == SIS |=> tap == TLR)
        else $error("tap did not return to reset");
    a_freq_reserved: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        o_freq_reserved == (o_freq_sel == 2'h0))
        else $error("reserved frequency flag wrong");
    c_frame_edge: cover property (@(posedge i_mclk) disable iff (!i_rstn) fp_rise && aligned);
    c_manual_second: cover property (@(posedge i_mclk) disable iff (!i_rstn) o_manual && o_use_secondary);
    c_holdover: cover property (@(posedge i_mclk) disable iff (!i_rstn) o_state == SRM_HOLDOVER_C);
    c_tap_shift: cover property (@(posedge i_mclk) disable iff (!i_rstn) tap == SHD);
endmodule // srm_sync_ref_mode
`default_nettype wire

// File: rtl/srm_pkg.sv
package srm_pkg;
    localparam int unsigned CLK_HZ       = 125000000;
    localparam int unsigned FRAME_HZ     = 8000;
    localparam int unsigned FRAME_CYC    = CLK_HZ / FRAME_HZ;
    localparam int unsigned PULSE_NS     = 122;
    localparam int unsigned CLK_NS       = 8;
    localparam int unsigned PULSE_CYC    = PULSE_NS / CLK_NS;
    localparam int unsigned RST_MIN_NS   = 300;
    localparam int unsigned RST_MIN_CYC  = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0]  FREQ_RSVD    = 2'h0;
    localparam logic [1:0]  FREQ_8K      = 2'h1;
    localparam logic [1:0]  FREQ_1M544   = 2'h2;
    localparam logic [1:0]  FREQ_2M048   = 2'h3;
    localparam logic [1:0]  CTRL_RESET   = 2'h0;
    typedef enum logic [1:0] {
        SRM_NORMAL,
        SRM_HOLDOVER,
        SRM_FREERUN
    } srm_state_t;
endpackage : srm_pkg

// File: bench/srm_board_model.sv
`timescale 1ns/10ps
`default_nettype none
module srm_board_model #(
    parameter int unsigned REF_CYC = 64
) (
    input  wire logic i_mclk,
    input  wire logic i_run,
    input  wire logic i_auto,
    input  wire logic i_pick_req,
    output logic      o_ref_align,
    output logic      o_ref_source_pick
);
    logic [15:0] cnt;
    always_ff @(posedge i_mclk) begin
        if (!i_run || cnt == 16'(REF_CYC - 1)) begin
            cnt <= 16'h0000;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end
    // reference edge a few cycles into each period, quiet while held in reset
    assign o_ref_align = i_run && cnt >= 16'h0008 && cnt < 16'h000C;
    assign o_ref_source_pick = i_auto ? 1'b0 : i_pick_req;
endmodule // srm_board_model
`default_nettype wire

// File: bench/tb_sync_reference_mode_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_sync_reference_mode_control;
    logic i_mclk, i_rstn, l1, l2, ms_lo, ms_hi, pick_req, fs_lo, fs_hi, ten, tck, tms, pho;
    localparam int TB_FRAME = 64;
    logic ref_al, pick, fp, clk_hi, alg, man, pick_second, p_lost, s_lost, fres, tmode, hold, oe_n;
    logic gtm, tdo, scan_en;
    logic [3:0] tap_st;
    logic [1:0] st, fsel;
    int failures, checks_done;
    srm_board_model u_board (.i_mclk(i_mclk), .i_run(i_rstn), .i_auto(!(ms_hi && ms_lo)),
        .i_pick_req(pick_req), .o_ref_align(ref_al), .o_ref_source_pick(pick));
    srm_sync_ref_mode #(.FRAME_CYC(TB_FRAME), .PULSE_CYC(srm_pkg::PULSE_CYC)) uut (
        .i_mclk(i_mclk), .i_rstn(i_rstn), .i_primary_ref_lost(l1), .i_secondary_ref_lost(l2),
        .i_guard_time_in(l1), .i_ctrl_select_low(ms_lo), .i_ctrl_select_high(ms_hi),
        .i_ref_source_pick(pick), .i_freq_pick_low(fs_lo), .i_freq_pick_high(fs_hi),
        .i_test_enable(ten), .i_ref_align(ref_al), .i_tck(tck), .i_tms(tms), .i_tdi(1'b1),
        .i_scan_tdo(1'b0), .i_pll_holdover(pho), .o_frame_pulse_8k(fp), .o_clocks_high(clk_hi),
        .o_phase_align(alg), .o_manual(man), .o_state(st), .o_use_secondary(pick_second),
        .o_primary_lost(p_lost), .o_secondary_lost(s_lost), .o_guard_time(gtm), .o_freq_sel(fsel),
        .o_freq_reserved(fres), .o_test_mode(tmode), .o_holdover(hold), .o_tdo(tdo),
        .o_tdo_oe_n(oe_n), .o_scan_enable(scan_en), .o_tap_state(tap_st));
    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic chk(input logic [3:0] seen, input logic [3:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // bounded wait for the frame pulse to reach the given level from the other one
    task automatic wait_fp(input logic lvl);
        int k;
        for (k = 0; k < 200 && !(fp === lvl); k++) tick(1);
        for (k = 0; k < 200 && fp === lvl; k++) tick(1);
        for (k = 0; k < 200 && !(fp === lvl); k++) tick(1);
    endtask
    task automatic do_reset(input int n);
        int k;
        i_rstn = 1'b0;
        tick(n / 2);
        chk({2'h0, clk_hi, fp}, 4'h3, "outputs high in reset");
        tick(n - n / 2);
        i_rstn = 1'b1;
        for (k = 0; k < 100 && alg !== 1'b1; k++) tick(1);
        chk({3'h0, alg}, 4'h1, "aligned after release");
        chk({3'h0, clk_hi}, 4'h0, "clocks released");
        $display("reset of %0d cycles done", n);
    endtask
    task automatic test_frame;
        int hi, per;
        wait_fp(1'b1);
        for (hi = 0; hi < 100 && fp === 1'b1; hi++) tick(1);
        for (per = hi; per < 200 && fp === 1'b0; per++) tick(1);
        chk(4'(hi >> 4), 4'h0, "pulse width high");
        chk(4'(hi), 4'(srm_pkg::PULSE_CYC), "pulse width");
        chk(4'(per >> 4), 4'(TB_FRAME >> 4), "frame period high");
        chk(4'(per), 4'(TB_FRAME), "frame period");
        $display("frame timing done");
    endtask
    // a change between automatic and manual control is followed by a reset
    task automatic apply(input logic [1:0] ms, input logic pk, input logic a, input logic b);
        logic swap;
        swap = (ms == 2'h3) != (ms_hi && ms_lo);
        wait_fp(1'b0);
        {ms_hi, ms_lo, pick_req, l1, l2} = {ms, pk, a, b};
        if (swap) do_reset(16);
    endtask
    task automatic test_modes;
        logic [1:0] se [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
        logic [1:0] pv [4] = '{2'h0, 2'h1, 2'h0, 2'h0};
        int i;
        for (i = 1; i <= 4; i++) begin
            apply(2'(i), 1'b0, 1'b0, 1'b0);
            tick(20);
            chk({2'h0, st}, {2'h0, pv[i - 1]}, "no change between edges");
            wait_fp(1'b1);
            tick(3);
            chk({2'h0, st}, {2'h0, se[i % 4]}, "state");
            chk({3'h0, man}, {3'h0, i == 3}, "manual");
            chk({3'h0, hold}, {3'h0, se[i % 4] == 2'h1}, "holdover flag");
        end
        $display("mode table done");
    endtask
    task automatic sel_case(input logic [1:0] ms, input logic pk, input logic a, input logic b,
                            input logic [3:0] exp);
        apply(ms, pk, a, b);
        wait_fp(1'b1);
        tick(3);
        chk({1'b0, pick_second, p_lost, s_lost}, exp, "reference choice");
        chk({3'h0, gtm}, {3'h0, a}, "guard time sample");
    endtask
    task automatic test_select;
        sel_case(2'h3, 1'b0, 1'b0, 1'b0, 4'h0);
        sel_case(2'h3, 1'b1, 1'b0, 1'b0, 4'h4);
        sel_case(2'h0, 1'b1, 1'b1, 1'b0, 4'h6);
        sel_case(2'h0, 1'b0, 1'b1, 1'b1, 4'h3);
        {l1, l2} = 2'h0;
        $display("reference select done");
    endtask
    // one test clock period: rising edge first, then falling edge, idle low
    task automatic tck_cycle(input logic m);
        tms = m;
        tck = 1'b1;
        tick(4);
        tck = 1'b0;
        tick(4);
    endtask
    task automatic test_misc;
        int i;
        for (i = 1; i < 4; i++) begin
            {fs_hi, fs_lo} = 2'(i);
            do_reset(16);
            chk({2'h0, fsel}, 4'(i), "frequency code");
            chk({3'h0, fres}, 4'h0, "reserved code");
        end
        for (i = 0; i < 2; i++) begin
            {ten, pho} = {2{!i[0]}};
            tick(5);
            chk({2'h0, tmode, hold}, {2'h0, !i[0], !i[0]}, "test and holdover");
        end
        for (i = 0; i < 6; i++) begin
            tck_cycle(1'b1);
            chk({3'h0, oe_n}, 4'h1, "scan output idle");
            chk(tap_st, 4'h0, "tap held in reset");
        end
        tck_cycle(1'b0);
        tck_cycle(1'b1);
        tck_cycle(1'b0);
        tck_cycle(1'b0);
        chk({2'h0, scan_en, oe_n}, 4'h2, "scan output driven in shift");
        chk(tap_st, 4'h4, "shift data state");
        tck_cycle(1'b0);
        chk({3'h0, tdo}, 4'h1, "data in shifted out");
        for (i = 0; i < 5; i++) begin
            tck_cycle(1'b1);
        end
        chk({2'h0, scan_en, oe_n}, 4'h1, "scan output released");
        chk(tap_st, 4'h0, "tap back in reset");
        $display("decode and test port done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {i_rstn, l1, l2, ms_lo, ms_hi, pick_req, fs_hi, ten, tck, tms, pho} = '0;
        fs_lo = 1'b1;
        failures = 0;
        checks_done = 0;
        do_reset(16);
        test_frame();
        test_modes();
        test_select();
        test_misc();
        do_reset(40);
        test_frame();
        final_report();
    end
    initial begin
        #100000;
        failures++;
        final_report();
    end
endmodule // tb_sync_reference_mode_control
`default_nettype wire
